// *** rtl/seq_step_defines.vh ***
// constants for the sequencer stack entries 15 to 17
`ifndef SEQ_STEP_DEFINES_VH
`define SEQ_STEP_DEFINES_VH

// ----------------------------------------
// register map (printed offsets are indices, byte address = 4 x index)
// ----------------------------------------
`define STEP_15_INDEX        6'h2F
`define STEP_16_INDEX        6'h30
`define STEP_17_INDEX        6'h31
`define STEP_COUNT           2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define STEP_15_RESET        16'h5E00
`define STEP_16_RESET        16'h6000
`define STEP_17_RESET        16'h6200

// ----------------------------------------
// field layout
// ----------------------------------------
`define FIELD_DIR_BIT        15
`define FIELD_ADDR_HI        14
`define FIELD_ADDR_LO        9
`define FIELD_RETURN_BIT     8
`define FIELD_CHB_HI         7
`define FIELD_CHB_LO         4
`define FIELD_CHA_HI         3
`define FIELD_CHA_LO         0

// ----------------------------------------
// sequencer control
// ----------------------------------------
`define FIRST_STEP           2'h0
`define LAST_STEP            2'h2

`endif

// *** rtl/sequencer_stack_entries.v ***
// wishbone register bank for sequencer stack entries 15 to 17 plus step walker
// Functional notes
// - bit 15: zero read, one write
// - bits 14:9 hold entry's own address
// - return flag zero: advance after conversion
// - return flag one: back to first entry
// - bits 7:4 pick converter b channel
// - bits 3:0 pick converter a channel
// - entry 15 at 0x2F, resets 0x5E00
// - entry 16 at 0x30, resets 0x6000
// - entry 17 at 0x31, resets 0x6200
`timescale 1ns/1ps
`include "seq_step_defines.vh"

module sequencer_stack_entries (
  input  wire        clk_i,          // system clock, 50 MHz
  input  wire        rst_i,          // synchronous reset, active high
  input  wire        cyc_i,          // wishbone cycle
  input  wire        stb_i,          // wishbone strobe
  input  wire        we_i,           // wishbone write enable
  input  wire [7:0]  adr_i,          // wishbone byte address
  input  wire [3:0]  sel_i,          // wishbone byte selects
  input  wire [31:0] dat_i,          // wishbone write data
  output reg  [31:0] dat_o,          // wishbone read data
  output reg         ack_o,          // wishbone acknowledge
  input  wire        conv_done_i,    // one-cycle pulse: conversion finished
  input  wire        seq_restart_i,  // one-cycle pulse: restart at first entry
  output reg  [1:0]  active_step_o,  // active entry, 0 = entry 15
  output reg  [3:0]  chan_a_o,       // converter a channel of active entry
  output reg  [3:0]  chan_b_o        // converter b channel of active entry
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire [5:0] word_index = adr_i[7:2];
  wire       req        = cyc_i & stb_i & ~ack_o;
  reg  [2:0] hit;
  reg  [15:0] rd_value;

  wire [15:0] value_w  [0:2];
  wire [2:0]  return_w;
  wire [3:0]  chan_a_w [0:2];
  wire [3:0]  chan_b_w [0:2];

  always @* begin
    hit = 3'h0;
    if (word_index == `STEP_15_INDEX) begin
      hit = 3'h1;
    end else if (word_index == `STEP_16_INDEX) begin
      hit = 3'h2;
    end else if (word_index == `STEP_17_INDEX) begin
      hit = 3'h4;
    end
  end

  always @* begin
    rd_value = 16'h0000;
    if (hit[0]) begin
      rd_value = value_w[0];
    end else if (hit[1]) begin
      rd_value = value_w[1];
    end else if (hit[2]) begin
      rd_value = value_w[2];
    end
  end

  // ----------------------------------------
  // entry registers, one per generate pass
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `STEP_COUNT; g = g + 1) begin : g_entry
      // byte lanes 0 and 1 carry the 16-bit entry; upper lanes are ignored
      wire [15:0] wr_merged = {sel_i[1] ? dat_i[15:8] : value_w[g][15:8],
                               sel_i[0] ? dat_i[7:0]  : value_w[g][7:0]};

      step_entry #(
        .RESET_VALUE((g == 0) ? `STEP_15_RESET :
                     (g == 1) ? `STEP_16_RESET : `STEP_17_RESET)
      ) entry_u (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wr_en_i     (req & we_i & hit[g]),
        .wr_data_i   (wr_merged),
        .value_o     (value_w[g]),
        .direction_o (),
        .return_o    (return_w[g]),
        .chan_b_o    (chan_b_w[g]),
        .chan_a_o    (chan_a_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // bus answer: one registered ack a cycle after the request, unmapped reads return zero
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req & ~we_i) begin
        dat_o <= {16'h0000, rd_value};
      end
    end
  end

  // ----------------------------------------
  // step walker over the three entries
  // ----------------------------------------
  // the last local entry wraps to the first as the stack edge of this bank
  reg [1:0] step_next;

  always @* begin
    step_next = active_step_o;
    if (seq_restart_i) begin
      step_next = `FIRST_STEP;
    end else if (conv_done_i) begin
      if (return_w[active_step_o]) begin
        step_next = `FIRST_STEP;
      end else if (active_step_o == `LAST_STEP) begin
        step_next = `FIRST_STEP;
      end else begin
        step_next = active_step_o + 2'h1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      active_step_o <= `FIRST_STEP;
      chan_a_o      <= 4'h0;
      chan_b_o      <= 4'h0;
    end else begin
      active_step_o <= step_next;
      chan_a_o      <= chan_a_w[step_next];
      chan_b_o      <= chan_b_w[step_next];
    end
  end

endmodule // sequencer_stack_entries

// *** rtl/step_entry.v ***
// one sequencer stack entry register with its fields broken out
`timescale 1ns/1ps
`include "seq_step_defines.vh"

module step_entry #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  input  wire        clk_i,       // system clock
  input  wire        rst_i,       // synchronous reset, active high
  input  wire        wr_en_i,     // write strobe for this entry
  input  wire [15:0] wr_data_i,   // merged write value
  output wire [15:0] value_o,     // stored entry
  output wire        direction_o, // access direction flag
  output wire        return_o,    // stack return flag
  output wire [3:0]  chan_b_o,    // converter b channel select
  output wire [3:0]  chan_a_o     // converter a channel select
);

  reg [15:0] entry_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      entry_reg <= RESET_VALUE;
    end else if (wr_en_i) begin
      entry_reg <= wr_data_i;
    end
  end

  assign value_o     = entry_reg;
  assign direction_o = entry_reg[`FIELD_DIR_BIT];
  assign return_o    = entry_reg[`FIELD_RETURN_BIT];
  assign chan_b_o    = entry_reg[`FIELD_CHB_HI:`FIELD_CHB_LO];
  assign chan_a_o    = entry_reg[`FIELD_CHA_HI:`FIELD_CHA_LO];

endmodule // step_entry

// *** verif/seq_stack_properties.sv ***
// checker for the stack entry bank: bus handshake and step walker
`timescale 1ns/1ps
module seq_stack_properties (
  input wire        clk_i,         // clock
  input wire        rst_i,         // reset
  input wire        cyc_i,         // cycle
  input wire        stb_i,         // strobe
  input wire        we_i,          // write
  input wire [7:0]  adr_i,         // address
  input wire [31:0] dat_o,         // read data
  input wire        ack_o,         // ack
  input wire        conv_done_i,   // done pulse
  input wire        seq_restart_i, // restart
  input wire [1:0]  active_step_o  // step
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_miss_rd; s_take ##0 (!we_i && (adr_i[7:2] < 6'h2F || adr_i[7:2] > 6'h31)); endsequence
  property p_ack_next; s_take |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_upper_zero; ack_o |-> dat_o[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data");
  property p_unmapped; s_miss_rd |=> dat_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_hold; !conv_done_i && !seq_restart_i |=> $stable(active_step_o); endproperty
  a_hold: assert property (p_hold) else $error("step moved");
  property p_restart; seq_restart_i |=> active_step_o == 2'h0; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_advance; conv_done_i && !seq_restart_i |=>
    active_step_o == 2'h0 || active_step_o == $past(active_step_o) + 2'h1; endproperty
  a_advance: assert property (p_advance) else $error("bad advance");
  property p_range; active_step_o != 2'h3; endproperty
  a_range: assert property (p_range) else $error("step range");
endmodule // seq_stack_properties
bind sequencer_stack_entries seq_stack_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .conv_done_i(conv_done_i),
  .seq_restart_i(seq_restart_i), .active_step_o(active_step_o));

// *** verif/tb_sequencer_stack_entries.sv ***
// self-checking bench for the stack entry bank
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sequencer_stack_entries;
  logic        clk_i = 0, rst_i = 1, conv_done_i = 0, seq_restart_i = 0, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, chan_a_o, chan_b_o;
  logic [31:0] dat_i, dat_o, c;
  logic [1:0]  active_step_o;
  logic [15:0] v[3], e, exp_q[$];
  int          num_errors = 0, cmp_count = 0, i;
  always #10 clk_i = ~clk_i;
  sequencer_stack_entries u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_done_i(conv_done_i),
    .seq_restart_i(seq_restart_i), .active_step_o(active_step_o), .chan_a_o(chan_a_o), .chan_b_o(chan_b_o));
  wb_host_model u_host (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
    .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    u_host.xfer(1'b1, a, s, {16'($urandom), d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    u_host.xfer(1'b0, a, 4'hF, 32'h0000_0000);
  endtask
  task automatic step(input logic d, r, input logic [1:0] s, input logic [7:0] ch);
    {conv_done_i, seq_restart_i} <= {d, r};
    @(posedge clk_i) {conv_done_i, seq_restart_i} <= 2'b00;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(active_step_o, s)
    `CHK({chan_b_o, chan_a_o}, ch)
    @(posedge clk_i);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) begin
    e = exp_q.pop_front();
    `CHK(dat_o, {16'h0000, e})
  end
  initial begin
    void'($urandom(15));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    `CHK({active_step_o, chan_b_o, chan_a_o}, 10'h000)
    @(posedge clk_i);
    rd(8'hBC, 16'h5E00);
    rd(8'hC0, 16'h6000);
    rd(8'hC4, 16'h6200);
    for (i = 0; i < 3; i++) begin
      v[i] = 16'($urandom);
      wr(8'hBC + 8'(4 * i), 4'h3, v[i]);
      rd(8'hBC + 8'(4 * i), v[i]);
    end
    wr(8'hC1, 4'h2, 16'hA5A5);
    rd(8'hC0, {8'hA5, v[1][7:0]});
    wr(8'hC8, 4'h3, 16'h1234);
    rd(8'hC8, 16'h0000);
    c = $urandom;
    wr(8'hBC, 4'h3, {8'h5E, c[7:0]});
    wr(8'hC0, 4'h3, {8'h61, c[15:8]});
    wr(8'hC4, 4'h3, {8'h62, c[23:16]});
    step(0, 0, 2'h0, c[7:0]);
    step(1, 0, 2'h1, c[15:8]);
    step(1, 0, 2'h0, c[7:0]);
    step(1, 0, 2'h1, c[15:8]);
    step(1, 1, 2'h0, c[7:0]);
    wr(8'hC0, 4'h3, {8'h60, c[15:8]});
    step(1, 0, 2'h1, c[15:8]);
    step(1, 0, 2'h2, c[23:16]);
    step(1, 0, 2'h0, c[7:0]);
    tally_and_finish;
  end
endmodule // tb_sequencer_stack_entries

// *** verif/wb_host_model.sv ***
// wishbone host model that drives configuration cycles
`timescale 1ns/1ps
module wb_host_model (
  input  wire         clk_i,      // clock
  input  wire         ack_i,      // ack
  output logic        cyc_o = '0, // cycle
  output logic        stb_o = '0, // strobe
  output logic        we_o = '0,  // write
  output logic [7:0]  adr_o = '0, // address
  output logic [3:0]  sel_o = '0, // selects
  output logic [31:0] dat_o = '0  // write data
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    if (ack_i !== 1'b1) begin
      tb_sequencer_stack_entries.num_errors++;
      tb_sequencer_stack_entries.tally_and_finish();
    end
    // released data never keeps its last value
    {cyc_o, stb_o, dat_o} <= {2'b00, ~d};
    @(posedge clk_i);
  endtask
endmodule // wb_host_model
